// ===== core/tlsr_map.vh
`ifndef TLSR_MAP_VH
`define TLSR_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TLSR_OFS_REM_OT      8'h07
`define TLSR_OFS_REM_OT_ALT  8'h0d
`define TLSR_OFS_REM_CRIT    8'h19
`define TLSR_OFS_LOC_LIMIT   8'h20
`define TLSR_OFS_HYST        8'h21
`define TLSR_OFS_STATUS2     8'h33
`define TLSR_OFS_MAKER_ID    8'hfe
`define TLSR_OFS_REVISION    8'hff

// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define TLSR_RST_REM_OT      8'h55
`define TLSR_RST_REM_CRIT    8'h6e
`define TLSR_RST_LOC_LIMIT   8'h55
`define TLSR_RST_HYST        5'h0a
`define TLSR_BIT_NOT_READY   7
`define TLSR_BIT_COMP_DET    6
`define TLSR_HYST_W          5

// ----------------------------------------------------------------
// timing: power-up wait in microseconds, clock in MHz
// ----------------------------------------------------------------
`define TLSR_PWRUP_US        30000
`define TLSR_CLK_MHZ         100
`define TLSR_PWRUP_CYC       (`TLSR_PWRUP_US * `TLSR_CLK_MHZ)

`endif

// ===== core/tlsr_limit_cmp.v
`include "tlsr_map.vh"

// comparator with hysteresis for one limit and one reading
module tlsr_limit_cmp (
    input  wire       CLOCK,
    input  wire       NRST,
    input  wire       upd,
    input  wire [7:0] reading,
    input  wire [7:0] limit,
    input  wire [4:0] hyst,
    output wire       flag
);
    reg        flag_q;
    wire [8:0] low_mark;

    // low mark borrows into bit 8 when hyst exceeds limit, and the flag then never clears
    assign low_mark = {1'b0, limit} - {4'h0, hyst};

    // ------------------------------------------------------------
    // set above limit, clear below limit minus hysteresis
    // ------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (!NRST) begin
            flag_q <= 1'b0;
        end else if (upd) begin
            if (reading > limit)
                flag_q <= 1'b1;
            else if (!low_mark[8] && reading < low_mark[7:0])
                flag_q <= 1'b0;
        end
    end

    assign flag = flag_q;
endmodule // tlsr_limit_cmp

// ===== core/tlsr_regs.v
// How it works
// - status2 bit 7 reads 1 during the 30 ms power-up wait, then 0.
// - status2 bit 6 reports compensation mode while a discrete transistor.
// - status2 bits 5 to 0 always read zero.
// - remote overtemp limit, 8-bit unsigned, resets to 55h.
// - one local limit serves both local comparisons, resets to 55h.
// - remote critical limit, 8-bit read/write, resets to 6Eh.
// - hysteresis holds 5 bits, upper bits read zero, resets to 0Ah.
// - maker identification is read-only and fixed.
// - die revision is read-only and fixed per die.
`include "tlsr_map.vh"

module tlsr_regs #(
    parameter [7:0]  MAKER_CODE = 8'h5a,   // arbitrary value
    parameter [7:0]  REV_CODE   = 8'h10,   // arbitrary value
    parameter [31:0] PWRUP_CYC  = `TLSR_PWRUP_CYC
) (
    input  wire       CLOCK,
    input  wire       NRST,
    input  wire [7:0] ADDR,
    input  wire [7:0] WDATA,
    input  wire       WR,
    input  wire       RD,
    output reg  [7:0] RDATA,
    input  wire       COMP_ENABLE,
    input  wire       DISCRETE_SENSOR,
    input  wire [7:0] REMOTE_TEMP,
    input  wire [7:0] LOCAL_TEMP,
    input  wire       TEMP_VALID,
    output wire       OVERTEMP_SHUTDOWN_FLAG,
    output wire       CRITICAL_TEMP_ALARM,
    output wire       REMOTE_OT_FLAG,
    output wire       REMOTE_CRIT_FLAG,
    output wire       LOCAL_FLAG
);
    reg  [7:0]  rem_ot_q;
    reg  [7:0]  rem_crit_q;
    reg  [7:0]  loc_limit_q;
    reg  [4:0]  hyst_q;
    reg  [31:0] pwrup_cnt_q;
    reg         not_ready_q;
    reg  [7:0]  rdata_d;
    wire [7:0]  status2;
    wire [2:0]  sel;

    // register select codes, shared by the write and read paths
    localparam [2:0] SEL_NONE     = 3'h0;
    localparam [2:0] SEL_REM_OT   = 3'h1;
    localparam [2:0] SEL_REM_CRIT = 3'h2;
    localparam [2:0] SEL_LOC      = 3'h3;
    localparam [2:0] SEL_HYST     = 3'h4;
    localparam [2:0] SEL_STATUS2  = 3'h5;
    localparam [2:0] SEL_MAKER    = 3'h6;
    localparam [2:0] SEL_REV      = 3'h7;

    // ------------------------------------------------------------
    // offset decode
    // ------------------------------------------------------------
    // one decode for both paths, so an alias cannot reach one side only
    function [2:0] reg_sel;
        input [7:0] ofs;
        begin
            case (ofs)
                `TLSR_OFS_REM_OT,
                `TLSR_OFS_REM_OT_ALT: reg_sel = SEL_REM_OT;
                `TLSR_OFS_REM_CRIT:   reg_sel = SEL_REM_CRIT;
                `TLSR_OFS_LOC_LIMIT:  reg_sel = SEL_LOC;
                `TLSR_OFS_HYST:       reg_sel = SEL_HYST;
                `TLSR_OFS_STATUS2:    reg_sel = SEL_STATUS2;
                `TLSR_OFS_MAKER_ID:   reg_sel = SEL_MAKER;
                `TLSR_OFS_REVISION:   reg_sel = SEL_REV;
                default:              reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    assign sel = reg_sel(ADDR);

    // ------------------------------------------------------------
    // power-up wait counter
    // ------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (!NRST) begin
            pwrup_cnt_q <= 32'h0000_0000;
            not_ready_q <= 1'b1;
        end else if (not_ready_q) begin
            if (pwrup_cnt_q >= PWRUP_CYC - 32'h1)
                not_ready_q <= 1'b0;
            pwrup_cnt_q <= pwrup_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // writable limits
    // ------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (!NRST) begin
            rem_ot_q    <= `TLSR_RST_REM_OT;
            rem_crit_q  <= `TLSR_RST_REM_CRIT;
            loc_limit_q <= `TLSR_RST_LOC_LIMIT;
            hyst_q      <= `TLSR_RST_HYST;
        end else if (WR) begin
            // writes to read-only or unknown offsets are dropped
            case (sel)
                SEL_REM_OT:   rem_ot_q    <= WDATA;
                SEL_REM_CRIT: rem_crit_q  <= WDATA;
                SEL_LOC:      loc_limit_q <= WDATA;
                SEL_HYST:     hyst_q      <= WDATA[`TLSR_HYST_W-1:0];
                default: ;
            endcase
        end
    end

    assign status2 = {not_ready_q, DISCRETE_SENSOR & COMP_ENABLE, 6'h00};

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always @* begin
        case (sel)
            SEL_REM_OT:   rdata_d = rem_ot_q;
            SEL_REM_CRIT: rdata_d = rem_crit_q;
            SEL_LOC:      rdata_d = loc_limit_q;
            SEL_HYST:     rdata_d = {3'h0, hyst_q};
            SEL_STATUS2:  rdata_d = status2;
            SEL_MAKER:    rdata_d = MAKER_CODE;
            SEL_REV:      rdata_d = REV_CODE;
            default:      rdata_d = 8'h00;
        endcase
    end

    // read data is registered, valid the cycle after RD
    always @(posedge CLOCK) begin
        if (!NRST)
            RDATA <= 8'h00;
        else if (RD)
            RDATA <= rdata_d;
    end

    // ------------------------------------------------------------
    // comparisons
    // ------------------------------------------------------------
    // remote overtemp compare
    tlsr_limit_cmp u_rem_ot (
        .CLOCK   (CLOCK),
        .NRST    (NRST),
        .upd     (TEMP_VALID),
        .reading (REMOTE_TEMP),
        .limit   (rem_ot_q),
        .hyst    (hyst_q),
        .flag    (REMOTE_OT_FLAG)
    );

    tlsr_limit_cmp u_rem_crit (
        .CLOCK   (CLOCK),
        .NRST    (NRST),
        .upd     (TEMP_VALID),
        .reading (REMOTE_TEMP),
        .limit   (rem_crit_q),
        .hyst    (hyst_q),
        .flag    (REMOTE_CRIT_FLAG)
    );

    // one local flag feeds both outputs
    tlsr_limit_cmp u_loc (
        .CLOCK   (CLOCK),
        .NRST    (NRST),
        .upd     (TEMP_VALID),
        .reading (LOCAL_TEMP),
        .limit   (loc_limit_q),
        .hyst    (hyst_q),
        .flag    (LOCAL_FLAG)
    );

    assign OVERTEMP_SHUTDOWN_FLAG = REMOTE_OT_FLAG | LOCAL_FLAG;
    assign CRITICAL_TEMP_ALARM    = REMOTE_CRIT_FLAG | LOCAL_FLAG;
endmodule // tlsr_regs

// ===== bench/tlsr_regs_props.sv
module tlsr_regs_props #(
    parameter [7:0]  MAKER_CODE = 8'h5a,       // arbitrary value
    parameter [7:0]  REV_CODE   = 8'h10,       // arbitrary value
    parameter [31:0] PWRUP_CYC  = 32'd3000000
) (
    input logic       CLOCK,
    input logic       NRST,
    input logic [7:0] ADDR,
    input logic       RD,
    input logic [7:0] RDATA,
    input logic       COMP_ENABLE,
    input logic       DISCRETE_SENSOR,
    input logic       TEMP_VALID,
    input logic       OVERTEMP_SHUTDOWN_FLAG,
    input logic       REMOTE_OT_FLAG,
    input logic       REMOTE_CRIT_FLAG,
    input logic       CRITICAL_TEMP_ALARM,
    input logic       LOCAL_FLAG
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] up_cnt = 32'h0;
    // cycles since reset release, saturating so it never wraps
    always @(posedge CLOCK) begin
        if (!NRST)
            up_cnt <= 32'h0;
        else if (up_cnt != 32'hffff_ffff)
            up_cnt <= up_cnt + 32'h1;
    end
    // all checks on one clock, quiet while reset is low
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    not_ready_a: assert property (RD && ADDR == 8'h33
        |=> RDATA[7] == $past(up_cnt < PWRUP_CYC)) else $error("not ready bit");
    crit_merge_a: assert property (CRITICAL_TEMP_ALARM ==
        (REMOTE_CRIT_FLAG | LOCAL_FLAG)) else $error("alarm merge");
    st2_low_a: assert property (RD && ADDR == 8'h33 |=> RDATA[5:0] == 6'h0)
        else $error("status low bits set");
    comp_det_a: assert property (RD && ADDR == 8'h33
        |=> RDATA[6] == $past(DISCRETE_SENSOR && COMP_ENABLE)) else $error("bit6");
    maker_fix_a: assert property (RD && ADDR == 8'hfe |=> RDATA == MAKER_CODE)
        else $error("maker code");
    rev_fix_a: assert property (RD && ADDR == 8'hff |=> RDATA == REV_CODE)
        else $error("revision code");
    hyst_top_a: assert property (RD && ADDR == 8'h21 |=> RDATA[7:5] == 3'h0)
        else $error("hysteresis top bits");
    shared_local_a: assert property (OVERTEMP_SHUTDOWN_FLAG ==
        (REMOTE_OT_FLAG | LOCAL_FLAG)) else $error("shutdown merge");
    flag_hold_a: assert property (!TEMP_VALID |=>
        $stable({REMOTE_OT_FLAG, LOCAL_FLAG})) else $error("flag moved");
    rdata_hold_a: assert property (!RD |=> $stable(RDATA))
        else $error("read data moved");
    cover property (RD && ADDR == 8'h33);
    cover property ($rose(REMOTE_OT_FLAG));
    cover property ($fell(REMOTE_OT_FLAG));
    cover property ($rose(REMOTE_CRIT_FLAG));
endmodule // tlsr_regs_props

bind tlsr_regs tlsr_regs_props #(.MAKER_CODE(MAKER_CODE),
    .REV_CODE(REV_CODE), .PWRUP_CYC(PWRUP_CYC)) u_props (.CLOCK, .NRST,
    .ADDR, .RD, .RDATA, .COMP_ENABLE, .DISCRETE_SENSOR, .TEMP_VALID,
    .OVERTEMP_SHUTDOWN_FLAG, .REMOTE_OT_FLAG, .REMOTE_CRIT_FLAG,
    .CRITICAL_TEMP_ALARM, .LOCAL_FLAG);

// ===== bench/tlsr_sense_model.sv
module tlsr_sense_model (
    input  logic       CLOCK,
    input  logic       go,
    input  logic [7:0] rem_in,
    input  logic [7:0] loc_in,
    output logic [7:0] rem_out = 8'h00,
    output logic [7:0] loc_out = 8'h00,
    output logic       valid = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // results hold between conversions, as the front end's result latch
    always_ff @(posedge CLOCK) begin
        valid <= go;
        if (go) begin
            rem_out <= rem_in;
            loc_out <= loc_in;
        end
    end
endmodule // tlsr_sense_model

// ===== bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       CLOCK = 0, NRST = 0, WR = 0, RD = 0, go = 0, TEMP_VALID;
    logic       COMP_ENABLE = 0, DISCRETE_SENSOR = 0;
    logic [7:0] ADDR = 0, WDATA = 0, rt = 0, lt = 0, RDATA, rtmp, ltmp;
    wire        osd, cta, rof, rcf, lcf;
    int         error_cnt = 0, num_checks = 0, cyc = 0;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
    tlsr_regs #(.PWRUP_CYC(32'd20)) uut (.CLOCK, .NRST, .ADDR, .WDATA, .WR,
        .RD, .RDATA, .COMP_ENABLE, .DISCRETE_SENSOR, .REMOTE_TEMP(rtmp),
        .LOCAL_TEMP(ltmp), .TEMP_VALID, .OVERTEMP_SHUTDOWN_FLAG(osd),
        .CRITICAL_TEMP_ALARM(cta), .REMOTE_OT_FLAG(rof),
        .REMOTE_CRIT_FLAG(rcf), .LOCAL_FLAG(lcf));
    tlsr_sense_model u_sense (.CLOCK, .go, .rem_in(rt), .loc_in(lt),
        .rem_out(rtmp), .loc_out(ltmp), .valid(TEMP_VALID));
    initial forever #5 CLOCK = ~CLOCK;
    // one strobe cycle per access, answer seen a cycle later
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(negedge CLOCK);
        ADDR = a;
        WDATA = d;
        WR = w;
        RD = !w;
        @(negedge CLOCK);
        WR = 0;
        RD = 0;
        if (!w) `CHK("rdata", d, RDATA)
    endtask
    task automatic conv(input logic [7:0] r, l, e);
        @(negedge CLOCK);
        rt = r;
        lt = l;
        go = 1;
        @(negedge CLOCK);
        go = 0;
        @(negedge CLOCK);
        `CHK("flags", e[2:0], {rof, lcf, osd})
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, the whole run needs under 200 cycles
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(negedge CLOCK);
        NRST = 1;
        acc(0, 8'h33, 8'h80);
        acc(0, 8'h07, 8'h55);
        acc(0, 8'h0d, 8'h55);
        acc(0, 8'h19, 8'h6e);
        acc(0, 8'h20, 8'h55);
        acc(0, 8'h21, 8'h0a);
        $display("reset test done");
        acc(1, 8'h21, 8'hff);
        acc(0, 8'h21, 8'h1f);
        acc(1, 8'h19, 8'hc8);
        acc(0, 8'h19, 8'hc8);
        acc(1, 8'hfe, 8'h00);
        acc(0, 8'hfe, 8'h5a);
        acc(1, 8'hff, 8'h00);
        acc(0, 8'hff, 8'h10);
        acc(0, 8'h50, 8'h00);
        $display("access test done");
        repeat (25) @(negedge CLOCK);
        acc(0, 8'h33, 8'h00);
        DISCRETE_SENSOR = 1;
        COMP_ENABLE = 1;
        acc(0, 8'h33, 8'h40);
        COMP_ENABLE = 0;
        acc(0, 8'h33, 8'h00);
        $display("status test done");
        acc(1, 8'h21, 8'h05);
        acc(1, 8'h07, 8'd100);
        acc(1, 8'h20, 8'h7f);
        conv(8'd101, 8'd20, 3'b101);
        conv(8'd95, 8'd20, 3'b101);
        conv(8'd94, 8'd20, 3'b000);
        conv(8'd201, 8'd20, 3'b101);
        `CHK("crit", 1'b1, rcf)
        conv(8'd20, 8'h80, 3'b011);
        `CHK("crit", 1'b0, rcf)
        `CHK("alarm", 1'b1, cta)
        $display("limit test done");
        summarize();
    end
endmodule // testbench
